/* File: src/byte_lane_data_access.sv */
/*
  byte lane data access: pointer file, accumulator halves, selector, mode
  bits and the sequencer that steers byte and 32-bit transfers to memory.
  assumes a memory that takes one strobe per cycle, never stalls, and
  returns read data in the cycle after the read strobe.
*/
// Added by the designer: the register offsets and the plain strobed port.
// Notes on behaviour
// - indexed byte address: pointer plus index or immediate
// - even offset: only low byte touched
// - odd offset: only high byte touched
// - other byte modes: only low byte touched
// - low byte load clears high; high keeps low
// - 32-bit accesses forced even, low word first
// - pointers never changed for alignment
// - bits 0-15 low word, 16-31 next
// - native needs object one, addressing zero
// - 3-bit selector picks wide pointer zero-seven
// - pointer halves separately addressable
// - accumulator halves, either is byte operand
// - product shift +4,1,0,-1..-6
// - immediates zero or sign extended
`timescale 1ns/100ps
module byte_lane_data_access #(
  parameter int PTR_NUM = lane_access_pkg::PTR_NUM
) (
  input wire logic mclk_i, // core clock, 200 MHz
  input wire logic srst_i, // synchronous reset, active high
  input wire logic [7:0] reg_addr_i, // register word address
  input wire logic [15:0] reg_wdata_i, // register write data
  input wire logic reg_wr_i, // register write strobe
  input wire logic reg_rd_i, // register read strobe
  output logic [15:0] reg_rdata_o, // read data, cycle after strobe
  input wire logic op_valid_i, // access request
  input wire lane_access_pkg::op_kind_type op_kind_i, // access kind
  input wire logic op_indexed_i, // indexed byte form
  input wire lane_access_pkg::offset_src_type op_offset_src_i, // offset source
  input wire logic [2:0] op_imm3_i, // 3-bit immediate offset
  input wire logic op_acc_high_i, // byte operand half select
  input wire logic [31:0] op_addr_i, // address for other modes
  output logic op_ready_o, // request may be taken
  output logic op_done_o, // access finished, one cycle
  output logic op_refused_o, // refusal pulse
  output logic [31:0] mem_addr_o, // memory word address
  output logic mem_rd_o, // memory read strobe
  output logic mem_wr_o, // memory write strobe
  output logic [1:0] mem_be_o, // byte enables, bit1 high byte
  output logic [15:0] mem_wdata_o, // memory write data
  input wire logic [15:0] mem_rdata_i, // memory read data
  input wire logic [21:0] imm_value_i, // immediate to extend
  input wire lane_access_pkg::imm_width_type imm_width_i, // immediate width
  input wire logic imm_signed_i, // sign extend immediate
  output logic [31:0] imm_ext_o, // extended immediate
  input wire logic [31:0] product_i, // product to shift
  output logic [31:0] product_shifted_o, // shifted product
  output logic native_mode_o // native operation mode
);

  function automatic logic is_load(input lane_access_pkg::op_kind_type k);
    is_load = (k == lane_access_pkg::OP_LOAD_BYTE_LSB) ||
              (k == lane_access_pkg::OP_LOAD_BYTE_MSB) ||
              (k == lane_access_pkg::OP_LOAD_LONG);
  endfunction

  function automatic logic is_long(input lane_access_pkg::op_kind_type k);
    is_long = (k == lane_access_pkg::OP_LOAD_LONG) || (k == lane_access_pkg::OP_STORE_LONG);
  endfunction

  logic [15:0] ptr_low_reg [PTR_NUM];
  logic [15:0] ptr_high_reg [PTR_NUM];
  logic [15:0] acc_low_reg;
  logic [15:0] acc_high_reg;
  logic [15:0] acc_low_next;
  logic [15:0] acc_high_next;
  logic [2:0] ptr_sel_reg;
  logic [1:0] status_one_reg;
  logic [3:0] pshift_reg;
  logic [15:0] reg_rdata_reg;
  lane_access_pkg::lane_state_type state_reg;
  lane_access_pkg::lane_state_type state_next;
  lane_access_pkg::op_kind_type kind_reg;
  logic hi_lane_reg;
  logic acc_high_sel_reg;
  logic [31:0] addr_reg;
  logic [31:0] mem_addr_next;
  logic mem_rd_next;
  logic mem_wr_next;
  logic [1:0] mem_be_next;
  logic [15:0] mem_wdata_next;
  logic done_reg;
  logic refused_reg;

  // operand and address formation
  wire native = status_one_reg[lane_access_pkg::OBJ_MODE_BIT] &
                ~status_one_reg[lane_access_pkg::ADDR_MODE_BIT];
  wire [31:0] sel_ptr = {ptr_high_reg[ptr_sel_reg], ptr_low_reg[ptr_sel_reg]};
  wire [15:0] index_reg_zero = ptr_low_reg[0];
  wire [15:0] index_reg_one = ptr_low_reg[1];
  wire [15:0] offset = (op_offset_src_i == lane_access_pkg::OFS_INDEX_ZERO) ? index_reg_zero :
                       (op_offset_src_i == lane_access_pkg::OFS_INDEX_ONE) ? index_reg_one :
                       {13'h0000, op_imm3_i};
  wire [31:0] indexed_addr = sel_ptr + {16'h0000, offset};
  wire offset_odd = offset[0];
  wire [31:0] eff_addr = op_indexed_i ? indexed_addr : op_addr_i;
  // only the indexed form may pick the high lane
  wire take_hi_lane = op_indexed_i & offset_odd;
  wire accept = op_valid_i & (state_reg == lane_access_pkg::ST_IDLE) & native;
  wire [15:0] acc_src_half = op_acc_high_i ? acc_high_reg : acc_low_reg;
  wire store_msb = (op_kind_i == lane_access_pkg::OP_STORE_BYTE_MSB);
  wire [7:0] store_byte = store_msb ? acc_src_half[15:8] : acc_src_half[7:0];
  wire [7:0] load_byte = hi_lane_reg ? mem_rdata_i[15:8] : mem_rdata_i[7:0];
  wire [15:0] acc_dst_half = acc_high_sel_reg ? acc_high_reg : acc_low_reg;
  wire [15:0] merged_half = (kind_reg == lane_access_pkg::OP_LOAD_BYTE_MSB) ?
                            {load_byte, acc_dst_half[7:0]} : {8'h00, load_byte};
  wire cap_low_word = (state_reg == lane_access_pkg::ST_WORD1) &&
                      (kind_reg == lane_access_pkg::OP_LOAD_LONG);
  wire cap_last = (state_reg == lane_access_pkg::ST_DONE) && is_load(kind_reg);

  // register port decode
  wire hit_ptr = (reg_addr_i <= lane_access_pkg::REG_PTR_LAST);
  wire [2:0] hit_ptr_idx = reg_addr_i[3:1];
  wire hit_ptr_high = reg_addr_i[0];
  wire wr_acc_low = reg_wr_i && (reg_addr_i == lane_access_pkg::REG_ACC_LOW);
  wire wr_acc_high = reg_wr_i && (reg_addr_i == lane_access_pkg::REG_ACC_HIGH);
  wire wr_ptr_sel = reg_wr_i && (reg_addr_i == lane_access_pkg::REG_PTR_SEL);
  wire wr_status = reg_wr_i && (reg_addr_i == lane_access_pkg::REG_STATUS_ONE);
  wire wr_pshift = reg_wr_i && (reg_addr_i == lane_access_pkg::REG_PSHIFT);
  wire [15:0] state_word = {14'h0000, native, state_reg != lane_access_pkg::ST_IDLE};
  wire [15:0] ptr_read = hit_ptr_high ? ptr_high_reg[hit_ptr_idx] : ptr_low_reg[hit_ptr_idx];
  logic [15:0] read_mux;

  always_comb begin
    if (hit_ptr) begin
      read_mux = ptr_read;
    end else if (reg_addr_i == lane_access_pkg::REG_ACC_LOW) begin
      read_mux = acc_low_reg;
    end else if (reg_addr_i == lane_access_pkg::REG_ACC_HIGH) begin
      read_mux = acc_high_reg;
    end else if (reg_addr_i == lane_access_pkg::REG_PTR_SEL) begin
      read_mux = {13'h0000, ptr_sel_reg};
    end else if (reg_addr_i == lane_access_pkg::REG_STATUS_ONE) begin
      read_mux = {14'h0000, status_one_reg};
    end else if (reg_addr_i == lane_access_pkg::REG_PSHIFT) begin
      read_mux = {12'h000, pshift_reg};
    end else if (reg_addr_i == lane_access_pkg::REG_STATE) begin
      read_mux = state_word;
    end else begin
      read_mux = 16'h0000;
    end
  end

  // no access ever moves a pointer, so an odd pointer stays odd
  genvar gi;
  generate
    for (gi = 0; gi < PTR_NUM; gi++) begin : g_ptr
      wire wr_hit = reg_wr_i && hit_ptr && (hit_ptr_idx == 3'(gi));
      always_ff @(posedge mclk_i) begin
        if (srst_i) begin
          ptr_low_reg[gi] <= lane_access_pkg::WORD_RST;
          ptr_high_reg[gi] <= lane_access_pkg::WORD_RST;
        end else if (wr_hit && !hit_ptr_high) begin
          ptr_low_reg[gi] <= reg_wdata_i;
        end else if (wr_hit && hit_ptr_high) begin
          ptr_high_reg[gi] <= reg_wdata_i;
        end
      end
    end
  endgenerate

  // accumulator: a capture from memory takes precedence over a port write
  always_comb begin
    acc_low_next = wr_acc_low ? reg_wdata_i : acc_low_reg;
    acc_high_next = wr_acc_high ? reg_wdata_i : acc_high_reg;
    if (cap_low_word) begin
      acc_low_next = mem_rdata_i;
    end
    if (cap_last && kind_reg == lane_access_pkg::OP_LOAD_LONG) begin
      acc_high_next = mem_rdata_i;
    end else if (cap_last && acc_high_sel_reg) begin
      acc_high_next = merged_half;
    end else if (cap_last) begin
      acc_low_next = merged_half;
    end
  end

  // access sequencer
  always_comb begin
    state_next = state_reg;
    mem_addr_next = mem_addr_o;
    mem_rd_next = 1'b0;
    mem_wr_next = 1'b0;
    mem_be_next = mem_be_o;
    mem_wdata_next = mem_wdata_o;
    case (state_reg)
      lane_access_pkg::ST_IDLE: begin
        if (accept) begin
          state_next = lane_access_pkg::ST_WORD0;
          mem_rd_next = is_load(op_kind_i);
          mem_wr_next = !is_load(op_kind_i);
          if (is_long(op_kind_i)) begin
            mem_addr_next = {eff_addr[31:1], 1'b0};
            mem_be_next = lane_access_pkg::BE_BOTH;
            mem_wdata_next = acc_low_reg;
          end else begin
            mem_addr_next = eff_addr;
            mem_be_next = take_hi_lane ? lane_access_pkg::BE_HIGH :
                          lane_access_pkg::BE_LOW;
            mem_wdata_next = {store_byte, store_byte};
          end
        end
      end
      lane_access_pkg::ST_WORD0: begin
        if (is_long(kind_reg)) begin
          state_next = lane_access_pkg::ST_WORD1;
          mem_addr_next = {addr_reg[31:1], 1'b1};
          mem_rd_next = is_load(kind_reg);
          mem_wr_next = !is_load(kind_reg);
          mem_wdata_next = acc_high_reg;
        end else begin
          state_next = lane_access_pkg::ST_DONE;
        end
      end
      lane_access_pkg::ST_WORD1: begin
        state_next = lane_access_pkg::ST_DONE;
      end
      lane_access_pkg::ST_DONE: begin
        state_next = lane_access_pkg::ST_IDLE;
      end
      default: begin
        state_next = lane_access_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state_reg <= lane_access_pkg::ST_IDLE;
      mem_addr_o <= 32'h0000_0000;
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_be_o <= 2'h0;
      mem_wdata_o <= 16'h0000;
    end else begin
      state_reg <= state_next;
      mem_addr_o <= mem_addr_next;
      mem_rd_o <= mem_rd_next;
      mem_wr_o <= mem_wr_next;
      mem_be_o <= mem_be_next;
      mem_wdata_o <= mem_wdata_next;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      kind_reg <= lane_access_pkg::OP_LOAD_BYTE_LSB;
      hi_lane_reg <= 1'b0;
      acc_high_sel_reg <= 1'b0;
      addr_reg <= 32'h0000_0000;
    end else if (accept) begin
      kind_reg <= op_kind_i;
      hi_lane_reg <= take_hi_lane & ~is_long(op_kind_i);
      acc_high_sel_reg <= op_acc_high_i;
      addr_reg <= eff_addr;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      acc_low_reg <= lane_access_pkg::WORD_RST;
      acc_high_reg <= lane_access_pkg::WORD_RST;
      ptr_sel_reg <= lane_access_pkg::PTR_SEL_RST;
      status_one_reg <= lane_access_pkg::STATUS_ONE_RST;
      pshift_reg <= lane_access_pkg::PSHIFT_RST;
      reg_rdata_reg <= 16'h0000;
      done_reg <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      acc_low_reg <= acc_low_next;
      acc_high_reg <= acc_high_next;
      if (wr_ptr_sel) begin
        ptr_sel_reg <= reg_wdata_i[2:0];
      end
      if (wr_status) begin
        status_one_reg <= reg_wdata_i[1:0];
      end
      if (wr_pshift) begin
        pshift_reg <= reg_wdata_i[3:0];
      end
      reg_rdata_reg <= reg_rd_i ? read_mux : 16'h0000;
      done_reg <= (state_reg == lane_access_pkg::ST_DONE);
      refused_reg <= op_valid_i && (state_reg == lane_access_pkg::ST_IDLE) && !native;
    end
  end

  assign reg_rdata_o = reg_rdata_reg;
  assign op_ready_o = (state_reg == lane_access_pkg::ST_IDLE);
  assign op_done_o = done_reg;
  assign op_refused_o = refused_reg;
  assign native_mode_o = native;

  imm_extend u_imm_extend (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .imm_value_i(imm_value_i),
    .imm_width_i(imm_width_i),
    .imm_signed_i(imm_signed_i),
    .imm_ext_o(imm_ext_o)
  );

  product_shift u_product_shift (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .product_i(product_i),
    .shift_sel_i(pshift_reg),
    .product_shifted_o(product_shifted_o)
  );

endmodule

/* File: src/imm_extend.sv */
/*
  immediate extender: 7 to 22 bit immediates widened to 32 bits, registered.
  assumes the decoder gives width and sign choice.
*/
`timescale 1ns/100ps
module imm_extend (
  input wire logic mclk_i, // core clock
  input wire logic srst_i, // synchronous reset
  input wire logic [21:0] imm_value_i, // raw immediate, right aligned
  input wire lane_access_pkg::imm_width_type imm_width_i, // immediate width
  input wire logic imm_signed_i, // 1 sign extend, 0 zero extend
  output logic [31:0] imm_ext_o // extended immediate
);
  logic [4:0] top_bit;
  logic [31:0] mask;
  logic sign;
  logic [31:0] ext_next;

  always_comb begin
    case (imm_width_i)
      lane_access_pkg::IMM_W7: top_bit = 5'd6;
      lane_access_pkg::IMM_W8: top_bit = 5'd7;
      lane_access_pkg::IMM_W10: top_bit = 5'd9;
      lane_access_pkg::IMM_W16: top_bit = 5'd15;
      default: top_bit = 5'd21;
    endcase
  end

  assign mask = (32'h0000_0002 << top_bit) - 32'h0000_0001;
  assign sign = imm_signed_i & imm_value_i[top_bit];
  assign ext_next = ({10'h000, imm_value_i} & mask) | (sign ? ~mask : 32'h0000_0000);

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      imm_ext_o <= 32'h0000_0000;
    end else begin
      imm_ext_o <= ext_next;
    end
  end
endmodule

/* File: src/lane_access_pkg.sv */
/*
  constants and types shared by the byte lane data access block.
  assumes a systemverilog compiler only.
*/
package lane_access_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 32;
  localparam int REG_ADDR_W = 8;
  localparam int PTR_NUM = 8;
  localparam int PTR_SEL_W = 3;
  localparam int PSHIFT_W = 4;
  localparam int IMM_W = 22;
  localparam int IMM3_W = 3;

  // register offsets, one 16-bit word each
  localparam logic [7:0] REG_PTR_BASE = 8'h00;
  localparam logic [7:0] REG_PTR_LAST = 8'h0f;
  localparam logic [7:0] REG_ACC_LOW = 8'h10;
  localparam logic [7:0] REG_ACC_HIGH = 8'h11;
  localparam logic [7:0] REG_PTR_SEL = 8'h12;
  localparam logic [7:0] REG_STATUS_ONE = 8'h13;
  localparam logic [7:0] REG_PSHIFT = 8'h14;
  localparam logic [7:0] REG_STATE = 8'h15;

  // field positions
  localparam int OBJ_MODE_BIT = 0;
  localparam int ADDR_MODE_BIT = 1;
  localparam int STATE_BUSY_BIT = 0;
  localparam int STATE_NATIVE_BIT = 1;

  // reset values and byte enable codes
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [1:0] STATUS_ONE_RST = 2'h0;
  localparam logic [2:0] PTR_SEL_RST = 3'h0;
  localparam logic [3:0] PSHIFT_RST = 4'h2;
  localparam logic [1:0] BE_LOW = 2'h1;
  localparam logic [1:0] BE_HIGH = 2'h2;
  localparam logic [1:0] BE_BOTH = 2'h3;

  typedef enum logic [2:0] {
    OP_LOAD_BYTE_LSB = 3'h0,
    OP_LOAD_BYTE_MSB = 3'h1,
    OP_STORE_BYTE_LSB = 3'h2,
    OP_STORE_BYTE_MSB = 3'h3,
    OP_LOAD_LONG = 3'h4,
    OP_STORE_LONG = 3'h5
  } op_kind_type;

  typedef enum logic [1:0] {
    OFS_INDEX_ZERO = 2'h0,
    OFS_INDEX_ONE = 2'h1,
    OFS_IMM3 = 2'h2
  } offset_src_type;

  typedef enum logic [2:0] {
    IMM_W7 = 3'h0,
    IMM_W8 = 3'h1,
    IMM_W10 = 3'h2,
    IMM_W16 = 3'h3,
    IMM_W22 = 3'h4
  } imm_width_type;

  // product shift settings: left 4, left 1, none, right 1 .. right 6
  typedef enum logic [3:0] {
    PSH_LEFT4 = 4'h0,
    PSH_LEFT1 = 4'h1,
    PSH_NONE = 4'h2,
    PSH_RIGHT1 = 4'h3,
    PSH_RIGHT2 = 4'h4,
    PSH_RIGHT3 = 4'h5,
    PSH_RIGHT4 = 4'h6,
    PSH_RIGHT5 = 4'h7,
    PSH_RIGHT6 = 4'h8
  } pshift_type;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WORD0 = 4'b0010,
    ST_WORD1 = 4'b0100,
    ST_DONE = 4'b1000
  } lane_state_type;

endpackage

/* File: src/product_shift.sv */
/*
  product shifter: selected shift on a 32-bit product, arithmetic right.
  assumes the setting comes from the shift select register.
*/
`timescale 1ns/100ps
module product_shift (
  input wire logic mclk_i, // core clock
  input wire logic srst_i, // synchronous reset
  input wire logic [31:0] product_i, // raw product
  input wire logic [3:0] shift_sel_i, // product shift select setting
  output logic [31:0] product_shifted_o // shifted product
);
  logic signed [31:0] prod_s;
  logic [31:0] shifted;

  assign prod_s = product_i;

  always_comb begin
    case (shift_sel_i)
      lane_access_pkg::PSH_LEFT4: shifted = product_i << 4;
      lane_access_pkg::PSH_LEFT1: shifted = product_i << 1;
      lane_access_pkg::PSH_RIGHT1: shifted = prod_s >>> 1;
      lane_access_pkg::PSH_RIGHT2: shifted = prod_s >>> 2;
      lane_access_pkg::PSH_RIGHT3: shifted = prod_s >>> 3;
      lane_access_pkg::PSH_RIGHT4: shifted = prod_s >>> 4;
      lane_access_pkg::PSH_RIGHT5: shifted = prod_s >>> 5;
      lane_access_pkg::PSH_RIGHT6: shifted = prod_s >>> 6;
      // unused codes behave as no shift
      default: shifted = product_i;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      product_shifted_o <= 32'h0000_0000;
    end else begin
      product_shifted_o <= shifted;
    end
  end
endmodule

/* File: tb/lane_access_monitor.sv */
/*
  checker for byte_lane_data_access: lane steering, alignment, timing.
  assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/100ps
module lane_access_monitor (
  input wire logic mclk_i, // core clock
  input wire logic srst_i, // synchronous reset
  input wire logic op_valid_i, // access request
  input wire lane_access_pkg::op_kind_type op_kind_i, // access kind
  input wire logic op_indexed_i, // indexed byte form
  input wire lane_access_pkg::offset_src_type op_offset_src_i, // offset source
  input wire logic [2:0] op_imm3_i, // immediate offset
  input wire logic [31:0] op_addr_i, // direct address
  input wire logic op_ready_o, // idle
  input wire logic op_done_o, // finished pulse
  input wire logic op_refused_o, // refusal pulse
  input wire logic [31:0] mem_addr_o, // memory address
  input wire logic mem_rd_o, // read strobe
  input wire logic mem_wr_o, // write strobe
  input wire logic [1:0] mem_be_o, // byte enables
  input wire logic native_mode_o, // native mode
  input wire logic [21:0] imm_value_i, // raw immediate
  input wire lane_access_pkg::imm_width_type imm_width_i, // immediate width
  input wire logic imm_signed_i, // sign extend
  input wire logic [31:0] imm_ext_o // extended immediate
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  wire take = op_valid_i && op_ready_o && native_mode_o;
  wire take_byte = take && !op_kind_i[2];
  wire take_long = take && op_kind_i[2];
  wire imm_ix = take_byte && op_indexed_i && op_offset_src_i == lane_access_pkg::OFS_IMM3;
  wire [30:0] addr_top = op_addr_i[31:1];
  wire [31:0] imm16s = {{16{imm_value_i[15]}}, imm_value_i[15:0]};
  property p_refuse;
    op_valid_i && op_ready_o && !native_mode_o |=> op_refused_o && !mem_rd_o && !mem_wr_o;
  endproperty
  a_refuse: assert property (p_refuse) else $error("request not refused");
  property p_byte_direct;
    take_byte && !op_indexed_i |=> mem_be_o == lane_access_pkg::BE_LOW && mem_addr_o == $past(op_addr_i);
  endproperty
  a_byte_direct: assert property (p_byte_direct) else $error("direct byte lane wrong");
  property p_imm_odd;
    imm_ix && op_imm3_i[0] |=> mem_be_o == lane_access_pkg::BE_HIGH;
  endproperty
  a_imm_odd: assert property (p_imm_odd) else $error("odd offset not high lane");
  property p_imm_even;
    imm_ix && !op_imm3_i[0] |=> mem_be_o == lane_access_pkg::BE_LOW;
  endproperty
  a_imm_even: assert property (p_imm_even) else $error("even offset not low lane");
  property p_long_addr;
    take_long && !op_indexed_i |=> mem_addr_o == {$past(addr_top), 1'b0} &&
      mem_be_o == lane_access_pkg::BE_BOTH ##1 mem_addr_o == {$past(addr_top, 2), 1'b1};
  endproperty
  a_long_addr: assert property (p_long_addr) else $error("long access not aligned");
  property p_byte_time;
    take_byte |=> (mem_rd_o || mem_wr_o) ##1 !op_done_o ##1 op_done_o;
  endproperty
  a_byte_time: assert property (p_byte_time) else $error("byte access timing wrong");
  property p_long_time;
    take_long |=> !op_done_o [*3] ##1 op_done_o;
  endproperty
  a_long_time: assert property (p_long_time) else $error("long access timing wrong");
  property p_imm16s;
    imm_width_i == lane_access_pkg::IMM_W16 && imm_signed_i |=> imm_ext_o == $past(imm16s);
  endproperty
  a_imm16s: assert property (p_imm16s) else $error("16-bit sign extension wrong");
  c_byte: cover property (take_byte && op_indexed_i);
  c_long: cover property (take_long);
  c_refuse: cover property (op_refused_o);
endmodule
bind byte_lane_data_access lane_access_monitor mon_u (.*);

/* File: tb/tb_byte_lane_data_access.sv */
/*
  random self-checking bench for byte_lane_data_access.
  assumes the memory model and checker are compiled before it.
*/
`timescale 1ns/100ps
module tb_byte_lane_data_access;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, op_valid_i = 1'b0, op_indexed_i = 1'b0;
  logic op_acc_high_i = 1'b0, imm_signed_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic [2:0] op_imm3_i = 3'h0;
  logic [31:0] op_addr_i = 32'h0, product_i = 32'h0;
  logic [21:0] imm_value_i = 22'h0;
  lane_access_pkg::op_kind_type op_kind_i = lane_access_pkg::OP_LOAD_BYTE_LSB;
  lane_access_pkg::offset_src_type op_offset_src_i = lane_access_pkg::OFS_INDEX_ZERO;
  lane_access_pkg::imm_width_type imm_width_i = lane_access_pkg::IMM_W7;
  logic op_ready_o, op_done_o, op_refused_o, mem_rd_o, mem_wr_o, native_mode_o;
  logic [31:0] mem_addr_o, imm_ext_o, product_shifted_o;
  logic [15:0] reg_rdata_o, mem_wdata_o, mem_rdata_i, rv;
  logic [1:0] mem_be_o;
  logic [31:0] ptr [8];
  logic [15:0] acc [2];
  logic [2:0] sel = 3'h0;
  int seed = 64, mismatches = 0, n_tests = 0;
  byte_lane_data_access dut (.*);
  word_memory_model mem_u (.mclk_i(mclk_i), .mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o),
    .mem_wr_i(mem_wr_o), .mem_be_i(mem_be_o), .mem_wdata_i(mem_wdata_o),
    .mem_rdata_o(mem_rdata_i));
  initial forever #2.5 mclk_i = ~mclk_i;
  task automatic end_of_test;
    if (mismatches == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask
  function automatic logic [31:0] pexp(input int s, input logic [31:0] p);
    if (s == 0) return p << 4;
    if (s == 1) return p << 1;
    return $signed(p) >>> (s - 2);
  endfunction
  function automatic logic [31:0] iexp(input int w, input logic sg, input logic [21:0] v);
    int n;
    logic [31:0] m;
    n = w == 0 ? 7 : w == 1 ? 8 : w == 2 ? 10 : w == 3 ? 16 : 22;
    m = (32'h1 << n) - 32'h1;
    return (sg && v[n - 1]) ? ({10'h0, v} | ~m) : ({10'h0, v} & m);
  endfunction
  task automatic do_op(input int k, input logic ix, input int src, input logic [2:0] i3,
                       input logic hi, input logic [31:0] a);
    logic [31:0] ea;
    logic [15:0] off, w0, w1, h;
    logic [7:0] b;
    logic ln, dn;
    int ns;
    off = src == 0 ? ptr[0][15:0] : src == 1 ? ptr[1][15:0] : {13'h0, i3};
    ea = ix ? ptr[sel] + {16'h0, off} : a;
    ln = ix && off[0];
    if (k >= 4) ea[0] = 1'b0;
    w0 = mem_u.peek(ea);
    w1 = mem_u.peek(ea | 32'h1);
    h = acc[hi];
    b = ln ? w0[15:8] : w0[7:0];
    @(posedge mclk_i);
    op_valid_i <= 1'b1;
    op_kind_i <= lane_access_pkg::op_kind_type'(k);
    op_indexed_i <= ix;
    op_offset_src_i <= lane_access_pkg::offset_src_type'(src);
    op_imm3_i <= i3;
    op_acc_high_i <= hi;
    op_addr_i <= a;
    @(posedge mclk_i);
    op_valid_i <= 1'b0;
    ns = 0;
    dn = 1'b0;
    for (int i = 0; i < 8 && !dn; i++) begin
      #1;
      if (mem_rd_o === 1'b1 || mem_wr_o === 1'b1) begin
        chk(mem_addr_o, ea | 32'(ns));
        chk(mem_be_o, k >= 4 ? 2'h3 : ln ? 2'h2 : 2'h1);
        ns++;
      end
      chk(op_ready_o, op_done_o);
      dn = op_done_o === 1'b1;
      @(posedge mclk_i);
    end
    if (!dn) begin
      mismatches++;
      end_of_test();
    end
    chk(ns, k >= 4 ? 2 : 1);
    if (k == 0) acc[hi] = {8'h00, b};
    if (k == 1) acc[hi] = {b, h[7:0]};
    if (k == 4) acc = '{w0, w1};
    if (k == 5) {w1, w0} = {acc[1], acc[0]};
    b = k == 2 ? h[7:0] : h[15:8];
    if (k == 2 || k == 3) w0 = ln ? {b, w0[7:0]} : {w0[15:8], b};
    chk(mem_u.peek(ea), w0);
    if (k >= 4) chk(mem_u.peek(ea | 32'h1), w1);
    rd(lane_access_pkg::REG_ACC_LOW, rv);
    chk(rv, acc[0]);
    rd(lane_access_pkg::REG_ACC_HIGH, rv);
    chk(rv, acc[1]);
  endtask
  initial begin
    repeat (4) @(posedge mclk_i);
    srst_i <= 1'b0;
    for (int a = 0; a <= 8'h16; a++) begin
      rd(8'(a), rv);
      chk(rv, a == 8'h14 ? 32'h2 : 32'h0);
    end
    @(posedge mclk_i);
    op_valid_i <= 1'b1;
    @(posedge mclk_i);
    op_valid_i <= 1'b0;
    #1;
    chk(op_refused_o, 1'b1);
    wr(lane_access_pkg::REG_STATUS_ONE, 16'h0003);
    #1;
    chk(native_mode_o, 1'b0);
    wr(lane_access_pkg::REG_STATUS_ONE, 16'h0001);
    #1;
    chk(native_mode_o, 1'b1);
    for (int n = 0; n < 8; n++) begin
      ptr[n] = $random(seed) | 32'(n & 1);
      wr(8'(2 * n), ptr[n][15:0]);
      wr(8'(2 * n + 1), ptr[n][31:16]);
      if (n < 2) acc[n] = 16'($random(seed));
      if (n < 2) wr(8'(16 + n), acc[n]);
    end
    sel = 3'h5;
    wr(lane_access_pkg::REG_PTR_SEL, 16'h0005);
    do_op(5, 1'b1, 2, 3'h0, 1'b0, 32'h0);
    do_op(0, 1'b1, 2, 3'h3, 1'b0, 32'h0);
    do_op(3, 1'b1, 2, 3'h2, 1'b1, 32'h0);
    repeat (60) begin
      sel = 3'($random(seed));
      wr(lane_access_pkg::REG_PTR_SEL, {13'h0, sel});
      do_op({$random(seed)} % 6, 1'($random(seed)), {$random(seed)} % 3,
            3'($random(seed)), 1'($random(seed)), $random(seed));
    end
    for (int n = 0; n < 16; n++) begin
      rd(8'(n), rv);
      chk(rv, n[0] ? ptr[n / 2][31:16] : ptr[n / 2][15:0]);
    end
    for (int s = 0; s < 9; s++) begin
      wr(lane_access_pkg::REG_PSHIFT, 16'(s));
      product_i <= $random(seed);
      @(posedge mclk_i);
      #1;
      chk(product_shifted_o, pexp(s, product_i));
    end
    for (int w = 0; w < 10; w++) begin
      @(posedge mclk_i);
      imm_width_i <= lane_access_pkg::imm_width_type'(w / 2);
      imm_signed_i <= w[0];
      imm_value_i <= 22'($random(seed));
      @(posedge mclk_i);
      #1;
      chk(imm_ext_o, iexp(w / 2, imm_signed_i, imm_value_i));
    end
    end_of_test();
  end
endmodule

/* File: tb/word_memory_model.sv */
/*
  16-bit word memory model behind the data access port.
  assumes one strobe per cycle; read data wanted in the cycle after it.
*/
`timescale 1ns/100ps
module word_memory_model (
  input wire logic mclk_i, // core clock
  input wire logic [31:0] mem_addr_i, // word address
  input wire logic mem_rd_i, // read strobe
  input wire logic mem_wr_i, // write strobe
  input wire logic [1:0] mem_be_i, // byte enables
  input wire logic [15:0] mem_wdata_i, // write data
  output logic [15:0] mem_rdata_o // read data
);
  logic [15:0] mem [logic [31:0]];
  logic [15:0] w;
  // untouched words hold an address pattern, a plain zero wherever the low 16 address bits are 5a3c
  function automatic logic [15:0] peek(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : a[15:0] ^ 16'h5a3c;
  endfunction
  initial mem_rdata_o = 16'h0000;
  always @(posedge mclk_i) begin
    w = peek(mem_addr_i);
    if (mem_wr_i) begin
      if (mem_be_i[0]) w[7:0] = mem_wdata_i[7:0];
      if (mem_be_i[1]) w[15:8] = mem_wdata_i[15:8];
      mem[mem_addr_i] = w;
    end
    // data only good one cycle; flipped otherwise so stale reads show
    mem_rdata_o <= mem_rd_i ? w : ~mem_rdata_o;
  end
endmodule
